// ==== rtl/pin_decoder_pkg.sv ====
// Constants and carrier types for the multifunction pin decoder
`default_nettype none
package pin_decoder_pkg;
   localparam int          NUM_PINS    = 4;
   localparam int          NUM_PROXY   = 15;
   localparam int          ADDR_W      = 16;
   // Proxied control registers: general ones first, then loop a, then loop b
   localparam logic [15:0] PROXY_ADDR [NUM_PROXY] = '{
      16'h0005, 16'h0a00, 16'h0a02, 16'h0a03, 16'h0a05,
      16'h0a20, 16'h0a21, 16'h0a22, 16'h0a23, 16'h0a24,
      16'h0a40, 16'h0a41, 16'h0a42, 16'h0a43, 16'h0a44};
   // Bits that act once and clear themselves
   localparam logic [7:0]  STROBE_MASK [NUM_PROXY] = '{
      8'h01, 8'h04, 8'h00, 8'h00, 8'h8f,
      8'h04, 8'h00, 8'h00, 8'h02, 8'h07,
      8'h04, 8'h00, 8'h00, 8'h02, 8'h07};
   localparam logic [3:0]  IDX_UPDATE    = 4'h0;
   localparam logic [3:0]  IDX_GLOBAL    = 4'h1;
   localparam logic [3:0]  IDX_VALID_TO  = 4'h2;
   localparam logic [3:0]  IDX_FAULT     = 4'h3;
   localparam logic [3:0]  IDX_CLEAR     = 4'h4;
   localparam logic [3:0]  IDX_LOOP_A    = 4'h5;
   localparam logic [3:0]  LOOP_B_STEP   = 4'h5;
   localparam logic [15:0] PIN_CODE_BASE = 16'h0c00;
   localparam logic [15:0] STATUS_ADDR   = 16'h0d10;
   localparam int          SYNC_B_BIT    = 4;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  CODE_RESET    = 8'h00;
   localparam int          DIR_BIT       = 7;
   localparam logic [7:0]  IN_RSVD_FIRST = 8'h5e;
   localparam logic [7:0]  OUT_FIRST     = 8'h80;
   localparam logic [7:0]  OUT_HIGH      = 8'h81;
   localparam logic [7:0]  OUT_DIV32     = 8'h82;
   localparam logic [7:0]  OUT_WATCHDOG  = 8'h83;
   localparam logic [7:0]  OUT_IRQ_ANY   = 8'h90;
   localparam logic [7:0]  OUT_IRQ_COM   = 8'h91;
   localparam logic [7:0]  OUT_IRQ_B     = 8'h93;
   localparam logic [7:0]  OUT_SYNC_B    = 8'hdc;
   localparam logic [7:0]  OUT_RSVD_FIRST = 8'hdd;
   localparam int          STATUS_W      = 93;
   localparam int          CLK_PERIOD_NS = 5;
   localparam int          WD_STROBE_NS  = 40;
   localparam int          WD_CYCLES_INT = WD_STROBE_NS / CLK_PERIOD_NS;
   localparam logic [3:0]  WD_CYCLES     = 4'(WD_CYCLES_INT < 1 ? 1 : WD_CYCLES_INT);
   localparam int          DIV_W         = 5;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } bus_req_type;

   // Status bits indexed by output code minus 0x80
   typedef struct packed {
      logic [STATUS_W-1:0] bits;
      logic                wd_expire;
   } status_type;

   typedef struct packed {
      logic       hit;
      logic [3:0] idx;
      logic [7:0] mask;
   } map_type;

   typedef logic [NUM_PROXY-1:0][7:0] ctrl_type;
endpackage
`default_nettype wire

// ==== rtl/multifunction_pin_decoder.sv ====
// Multifunction pin decoder: per-pin function codes, control proxies and status routing
// Functional notes
// - Direction bit clear makes pin an input; 0x00 and 0x5E-0x7F do nothing.
// - Direction bit set drives a status signal; 0xDD-0xFF drive nothing.
// - Code 0xDC drives loop b distribution sync pulse, also status 0x0D10 bit 4.
// - Code 0x01 pin acts as register update strobe, register 0x0005 bit 0.
// - Code 0x02 full power-down, 0x04 divider sync, register 0x0A00 bits 0 and 2.
// - Code 0x03 clears watchdog, register 0x0A05 bit 7.
// - Codes 0x10-0x13 clear all, common, loop a, loop b interrupts; 0x0A05 bits 0-3.
// - Codes 0x20-0x23 force reference fault, 0x28-0x2B force validation timeout.
// - Codes 0x40-0x42 loop a power-down, user free-run, user holdover.
// - Code 0x43 resets loop a tuning-word history.
// - Codes 0x44-0x46 step up, step down, reset loop a phase offset.
// - Code 0x48 syncs loop a distribution outputs.
// - Codes 0x49-0x4B disable both, first or second loop a driver.
// - Codes 0x4C, 0x4D give loop a manual reference select bits 0 and 1.
// - Codes 0x50-0x56 give loop b the loop a controls.
// - Code 0x58 syncs loop b outputs; 0x59-0x5B disable its drivers.
// - Codes 0x5C, 0x5D give loop b manual reference select bits.
// - Code 0x83 drives 40 ns watchdog expiry strobe.
// - Code 0x90 drives OR of the three interrupt requests.
`default_nettype none
module multifunction_pin_decoder
   import pin_decoder_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire bus_req_type         bus,
   output logic [7:0]               rdata,
   input  wire status_type          status,
   input  wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0]      pin_out,
   output logic [NUM_PINS-1:0]      pin_oe,
   output ctrl_type                 ctrl
);

   typedef struct packed {
      logic [NUM_PROXY-1:0][7:0] regs;
      logic [NUM_PINS-1:0][7:0]  code;
      logic [NUM_PINS-1:0]       pin_prev;
      logic [NUM_PINS-1:0]       pin_out;
      logic [NUM_PINS-1:0]       pin_oe;
      ctrl_type                  ctrl;
      logic [3:0]                wd_cnt;
      logic [DIV_W-1:0]          div_cnt;
      logic [7:0]                rdata;
   } state_type;

   state_type st;
   state_type next_st;

   // Input code to proxied register and bit mask
   function automatic map_type input_map(input logic [7:0] code);
      map_type m;
      m = '{hit: 1'b0, idx: 4'h0, mask: 8'h00};
      if (!code[DIR_BIT] && code < IN_RSVD_FIRST) begin
         case (code[7:4])
            4'h0: begin
               case (code[3:0])
                  4'h1: m = '{hit: 1'b1, idx: IDX_UPDATE, mask: 8'h01};
                  4'h2: m = '{hit: 1'b1, idx: IDX_GLOBAL, mask: 8'h01};
                  4'h3: m = '{hit: 1'b1, idx: IDX_CLEAR, mask: 8'h80};
                  4'h4: m = '{hit: 1'b1, idx: IDX_GLOBAL, mask: 8'h04};
                  default: m.hit = 1'b0;
               endcase
            end
            4'h1: begin
               if (code[3:2] == 2'b00) begin
                  m = '{hit: 1'b1, idx: IDX_CLEAR, mask: 8'(8'h01 << code[1:0])};
               end
            end
            4'h2: begin
               if (code[2] == 1'b0) begin
                  m.hit  = 1'b1;
                  m.idx  = code[3] ? IDX_VALID_TO : IDX_FAULT;
                  m.mask = 8'(8'h01 << code[1:0]);
               end
            end
            4'h4, 4'h5: begin
               m.hit = 1'b1;
               m.idx = IDX_LOOP_A;
               case (code[3:0])
                  4'h0: m.mask = 8'h01;
                  4'h1: begin
                     m.idx  = IDX_LOOP_A + 4'h2;
                     m.mask = 8'h01;
                  end
                  4'h2: begin
                     m.idx  = IDX_LOOP_A + 4'h2;
                     m.mask = 8'h02;
                  end
                  4'h3: begin
                     m.idx  = IDX_LOOP_A + 4'h3;
                     m.mask = 8'h02;
                  end
                  4'h4, 4'h5, 4'h6: begin
                     m.idx  = IDX_LOOP_A + 4'h4;
                     m.mask = 8'(8'h01 << (code[1:0]));
                  end
                  4'h8: m.mask = 8'h04;
                  4'h9: begin
                     m.idx  = IDX_LOOP_A + 4'h1;
                     m.mask = 8'h0c;
                  end
                  4'ha, 4'hb: begin
                     m.idx  = IDX_LOOP_A + 4'h1;
                     m.mask = code[0] ? 8'h08 : 8'h04;
                  end
                  4'hc, 4'hd: begin
                     m.idx  = IDX_LOOP_A + 4'h2;
                     m.mask = code[0] ? 8'h40 : 8'h20;
                  end
                  default: m.hit = 1'b0;
               endcase
               if (code[4]) begin
                  m.idx = m.idx + LOOP_B_STEP;
               end
            end
            default: m.hit = 1'b0;
         endcase
      end
      return m;
   endfunction

   ctrl_type contrib;
   map_type  pin_map;
   logic     pin_edge;

   always_comb begin
      next_st  = st;
      contrib  = '0;
      pin_map  = '{hit: 1'b0, idx: 4'h0, mask: 8'h00};
      pin_edge = 1'b0;
      next_st.rdata = 8'h00;
      // Strobe bits last one cycle
      for (int i = 0; i < NUM_PROXY; i++) begin
         next_st.regs[i] = st.regs[i] & ~STROBE_MASK[i];
      end
      for (int i = 0; i < NUM_PROXY; i++) begin
         if (bus.wr && bus.addr == PROXY_ADDR[i]) begin
            next_st.regs[i] = bus.wdata;
         end
         if (bus.rd && bus.addr == PROXY_ADDR[i]) begin
            next_st.rdata = st.regs[i];
         end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         if (bus.wr && bus.addr == PIN_CODE_BASE + 16'(p)) begin
            next_st.code[p] = bus.wdata;
         end
         if (bus.rd && bus.addr == PIN_CODE_BASE + 16'(p)) begin
            next_st.rdata = st.code[p];
         end
      end
      if (bus.rd && bus.addr == STATUS_ADDR) begin
         next_st.rdata[SYNC_B_BIT] = status.bits[OUT_SYNC_B[6:0]];
      end
      // Pins acting as control inputs
      for (int p = 0; p < NUM_PINS; p++) begin
         pin_map  = input_map(st.code[p]);
         pin_edge = pin_in[p] & ~st.pin_prev[p];
         if (pin_map.hit) begin
            contrib[pin_map.idx] = contrib[pin_map.idx]
               | (pin_map.mask & STROBE_MASK[pin_map.idx] & {8{pin_edge}})
               | (pin_map.mask & ~STROBE_MASK[pin_map.idx] & {8{pin_in[p]}});
         end
      end
      for (int i = 0; i < NUM_PROXY; i++) begin
         next_st.ctrl[i] = st.regs[i] | contrib[i];
      end
      next_st.pin_prev = pin_in;
      next_st.div_cnt  = st.div_cnt + 5'h01;
      if (status.wd_expire) begin
         next_st.wd_cnt = WD_CYCLES;
      end else if (st.wd_cnt != 4'h0) begin
         next_st.wd_cnt = st.wd_cnt - 4'h1;
      end
      // Pins acting as status outputs
      for (int p = 0; p < NUM_PINS; p++) begin
         next_st.pin_oe[p]  = st.code[p][DIR_BIT] && st.code[p] < OUT_RSVD_FIRST;
         next_st.pin_out[p] = 1'b0;
         if (next_st.pin_oe[p]) begin
            case (st.code[p])
               OUT_FIRST:    next_st.pin_out[p] = 1'b0;
               OUT_HIGH:     next_st.pin_out[p] = 1'b1;
               OUT_DIV32:    next_st.pin_out[p] = st.div_cnt[DIV_W-1];
               OUT_WATCHDOG: next_st.pin_out[p] = st.wd_cnt != 4'h0;
               OUT_IRQ_ANY:  next_st.pin_out[p] = |status.bits[OUT_IRQ_B[6:0]:OUT_IRQ_COM[6:0]];
               default:      next_st.pin_out[p] = status.bits[st.code[p][6:0]];
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st.regs     <= {NUM_PROXY{REG_RESET}};
         st.code     <= {NUM_PINS{CODE_RESET}};
         st.pin_prev <= '0;
         st.pin_out  <= '0;
         st.pin_oe   <= '0;
         st.ctrl     <= '0;
         st.wd_cnt   <= 4'h0;
         st.div_cnt  <= '0;
         st.rdata    <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign rdata   = st.rdata;
   assign pin_out = st.pin_out;
   assign pin_oe  = st.pin_oe;
   assign ctrl    = st.ctrl;

   // Checks on pin 0 and on the watchdog counter, proxy registers and status read
   logic [7:0] code0;
   assign code0 = st.code[0];
   logic       rise0;
   assign rise0 = pin_in[0] & ~st.pin_prev[0];

   chk_input_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
      !code0[DIR_BIT] |=> !pin_oe[0])
      else $error("input code drives pin");
   chk_output_drive: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 >= OUT_FIRST && code0 < OUT_RSVD_FIRST) |=> pin_oe[0])
      else $error("output code not driving pin");
   chk_reserved_out: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 >= OUT_RSVD_FIRST) |=> (!pin_oe[0] && !pin_out[0]))
      else $error("reserved output code active");
   chk_sync_b_route: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == OUT_SYNC_B) |=> pin_out[0] == $past(status.bits[OUT_SYNC_B[6:0]]))
      else $error("sync pulse not routed");
   chk_update_edge: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h01 && pin_in[0] && !st.pin_prev[0]) |=> ctrl[IDX_UPDATE][0])
      else $error("update strobe missing");
   chk_power_level: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h02 && pin_in[0]) |=> ctrl[IDX_GLOBAL][0])
      else $error("power-down level missing");
   chk_fault_force: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h21 && pin_in[0]) |=> ctrl[IDX_FAULT][1])
      else $error("forced fault missing");
   chk_loop_b_holdover: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h52 && pin_in[0]) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP + 4'h2][1])
      else $error("loop b holdover missing");
   chk_wd_strobe_len: assert property (@(posedge ref_clk) disable iff (rst)
      (status.wd_expire ##1 (!status.wd_expire)[*8]) |=> st.wd_cnt == 4'h0)
      else $error("watchdog strobe too long");
   chk_irq_or: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == OUT_IRQ_ANY) |=> pin_out[0] == $past(|status.bits[19:17]))
      else $error("interrupt OR wrong");
   chk_strobe_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (bus.wr && bus.addr == PROXY_ADDR[4]) |=> st.regs[4] == $past(bus.wdata)
      ##1 ($past(bus.wr && bus.addr == PROXY_ADDR[4])
           || (st.regs[4] & STROBE_MASK[4]) == 8'h00))
      else $error("clear bits did not self-clear");

   chk_wd_clear_pin: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h03 && rise0) |=> ctrl[IDX_CLEAR][7])
      else $error("watchdog clear strobe missing");
   chk_div_sync_pin: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h04 && rise0) |=> ctrl[IDX_GLOBAL][2])
      else $error("divider sync strobe missing");
   chk_irq_clear_all: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h10 && rise0) |=> ctrl[IDX_CLEAR][0])
      else $error("clear all strobe missing");
   chk_irq_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h12 && rise0) |=> ctrl[IDX_CLEAR][2])
      else $error("loop a clear strobe missing");
   chk_irq_clear_b: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h13 && rise0) |=> ctrl[IDX_CLEAR][3])
      else $error("loop b clear strobe missing");
   chk_fault_first: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h20 && pin_in[0]) |=> ctrl[IDX_FAULT][0])
      else $error("first forced fault missing");
   chk_valid_timeout: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h2b && pin_in[0]) |=> ctrl[IDX_VALID_TO][3])
      else $error("forced validation timeout missing");
   chk_loop_a_power: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h40 && pin_in[0]) |=> ctrl[IDX_LOOP_A][0])
      else $error("loop a power-down missing");
   chk_loop_a_freerun: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h41 && pin_in[0]) |=> ctrl[IDX_LOOP_A + 4'h2][0])
      else $error("loop a free-run missing");
   chk_history_reset: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h43 && rise0) |=> ctrl[IDX_LOOP_A + 4'h3][1])
      else $error("loop a history reset missing");
   chk_phase_step: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h45 && rise0) |=> ctrl[IDX_LOOP_A + 4'h4][1])
      else $error("loop a phase step down missing");
   chk_loop_a_sync: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h48 && rise0) |=> ctrl[IDX_LOOP_A][2])
      else $error("loop a output sync missing");
   chk_driver_both: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h49 && pin_in[0]) |=> ctrl[IDX_LOOP_A + 4'h1][3:2] == 2'b11)
      else $error("loop a driver disable missing");
   chk_driver_second: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h4b && pin_in[0]) |=> ctrl[IDX_LOOP_A + 4'h1][3])
      else $error("loop a second driver disable missing");
   chk_ref_select_a: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h4d && pin_in[0]) |=> ctrl[IDX_LOOP_A + 4'h2][6])
      else $error("loop a reference select missing");
   chk_loop_b_power: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h50 && pin_in[0]) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP][0])
      else $error("loop b power-down missing");
   chk_loop_b_phase: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h56 && rise0) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP + 4'h4][2])
      else $error("loop b phase reset missing");
   chk_loop_b_sync: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h58 && rise0) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP][2])
      else $error("loop b output sync missing");
   chk_loop_b_driver: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h5a && pin_in[0]) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP + 4'h1][2])
      else $error("loop b driver disable missing");
   chk_ref_select_b: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == 8'h5c && pin_in[0]) |=> ctrl[IDX_LOOP_A + LOOP_B_STEP + 4'h2][5])
      else $error("loop b reference select missing");
   chk_reg_or_pin: assert property (@(posedge ref_clk) disable iff (rst)
      st.regs[IDX_LOOP_A + 4'h2][0] |=> ctrl[IDX_LOOP_A + 4'h2][0])
      else $error("register bit lost in control");
   chk_reserved_in: assert property (@(posedge ref_clk) disable iff (rst)
      ((code0 == 8'h00 || (!code0[DIR_BIT] && code0 >= IN_RSVD_FIRST))
       && st.code[3:1] == '0) |=> ctrl == $past(st.regs))
      else $error("reserved input code changed a control");
   chk_out_static_low: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == OUT_FIRST) |=> !pin_out[0])
      else $error("static low output wrong");
   chk_out_static_high: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == OUT_HIGH) |=> pin_out[0])
      else $error("static high output wrong");
   chk_status_read: assert property (@(posedge ref_clk) disable iff (rst)
      (bus.rd && bus.addr == STATUS_ADDR) |=> rdata == {3'b000, $past(status.bits[OUT_SYNC_B[6:0]]), 4'h0})
      else $error("sync status read wrong");
   chk_wd_start: assert property (@(posedge ref_clk) disable iff (rst)
      status.wd_expire |=> st.wd_cnt == WD_CYCLES)
      else $error("watchdog strobe not started");
   chk_wd_pin: assert property (@(posedge ref_clk) disable iff (rst)
      (code0 == OUT_WATCHDOG && st.wd_cnt != 4'h0) |=> pin_out[0])
      else $error("watchdog strobe not on pin");

   cov_output_mode: cover property (@(posedge ref_clk) disable iff (rst) pin_oe[0] && pin_out[0]);
   cov_pin_clear: cover property (@(posedge ref_clk) disable iff (rst)
      code0 == 8'h10 && pin_in[0] && !st.pin_prev[0]);
   cov_wd_strobe: cover property (@(posedge ref_clk) disable iff (rst)
      code0 == OUT_WATCHDOG && status.wd_expire);
   cov_strobe_write: cover property (@(posedge ref_clk) disable iff (rst) bus.wr && bus.addr == PROXY_ADDR[4]);
   cov_reserved_in: cover property (@(posedge ref_clk) disable iff (rst) code0 == IN_RSVD_FIRST && pin_in[0]);

endmodule
`default_nettype wire

// ==== tb/pin_board_model.sv ====
// Board-side model of the four multifunction pins
`default_nettype none
module pin_board_model (
   input  wire logic [3:0] drive,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   output logic [3:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Board changes its level only just after an edge, so each level stands a whole cycle
   always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule
`default_nettype wire

// ==== tb/test_multifunction_pin_decoder.sv ====
// Self-checking bench for the multifunction pin decoder
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_multifunction_pin_decoder
   import pin_decoder_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk;
   logic        rst;
   bus_req_type bus;
   logic [7:0]  rdata;
   status_type  status;
   logic [3:0]  drive;
   logic [3:0]  pin_in;
   logic [3:0]  pin_out;
   logic [3:0]  pin_oe;
   ctrl_type    ctrl;
   ctrl_type    x;
   int          miscompares;
   int          tests_run;
   int          seed;
   int          p;
   logic [7:0]  d;
   logic [7:0]  c;
   logic [12:0] e;
   logic [95:0] r;
   logic        exp;

   multifunction_pin_decoder dut_u (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .status(status),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ctrl(ctrl));
   pin_board_model board_u (.drive(drive), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Strobe flag, control index and bit mask for an input code
   function automatic logic [12:0] exp_map(input logic [7:0] k);
      logic [3:0] b;
      logic [3:0] n;
      b = k[4] ? IDX_LOOP_A + LOOP_B_STEP : IDX_LOOP_A;
      n = k[3:0];
      exp_map = 13'h0000;
      case (k) inside
         8'h01: exp_map = {1'b1, IDX_UPDATE, 8'h01};
         8'h02: exp_map = {1'b0, IDX_GLOBAL, 8'h01};
         8'h03: exp_map = {1'b1, IDX_CLEAR, 8'h80};
         8'h04: exp_map = {1'b1, IDX_GLOBAL, 8'h04};
         [8'h10:8'h13]: exp_map = {1'b1, IDX_CLEAR, 8'h01 << n};
         [8'h20:8'h23]: exp_map = {1'b0, IDX_FAULT, 8'h01 << n};
         [8'h28:8'h2b]: exp_map = {1'b0, IDX_VALID_TO, 8'h01 << (n - 4'h8)};
         [8'h40:8'h5d]: case (n)
            4'h0: exp_map = {1'b0, b, 8'h01};
            4'h1: exp_map = {1'b0, b + 4'h2, 8'h01};
            4'h2: exp_map = {1'b0, b + 4'h2, 8'h02};
            4'h3: exp_map = {1'b1, b + 4'h3, 8'h02};
            4'h4, 4'h5, 4'h6: exp_map = {1'b1, b + 4'h4, 8'h01 << (n - 4'h4)};
            4'h8: exp_map = {1'b1, b, 8'h04};
            4'h9: exp_map = {1'b0, b + 4'h1, 8'h0c};
            4'ha: exp_map = {1'b0, b + 4'h1, 8'h04};
            4'hb: exp_map = {1'b0, b + 4'h1, 8'h08};
            4'hc: exp_map = {1'b0, b + 4'h2, 8'h20};
            4'hd: exp_map = {1'b0, b + 4'h2, 8'h40};
            default: exp_map = 13'h0000;
         endcase
         default: exp_map = 13'h0000;
      endcase
   endfunction

   // Raise one pin under an input code and watch every control byte
   task automatic pulse_in(input logic [7:0] k, input int q);
      p = q;
      e = exp_map(k);
      x = '0;
      x[e[11:8]] = e[7:0];
      wr(PIN_CODE_BASE + 16'(p), k);
      @(posedge ref_clk);
      drive[p] <= 1'b1;
      tick(1);
      `CHK("ctrl on pin rise", x, ctrl)
      tick(1);
      `CHK("ctrl one cycle on", e[12] ? ctrl_type'(0) : x, ctrl)
      @(posedge ref_clk);
      drive[p] <= 1'b0;
      wr(PIN_CODE_BASE + 16'(p), 8'h00);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      summarize();
   end

   initial begin
      seed = 4;
      rst = 1'b1;
      bus = '0;
      status = '0;
      drive = 4'h0;
      miscompares = 0;
      tests_run = 0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(PIN_CODE_BASE + 16'(i), d);
         `CHK("code after reset", CODE_RESET, d)
      end
      `CHK("oe after reset", 4'h0, pin_oe)
      rd(16'h1234, d);
      `CHK("unmapped read", 8'h00, d)
      $display("test reset done");
      for (int i = 0; i < 512; i++) pulse_in(8'(i / 4), (i + i / 4) % 4);
      $display("test input codes done");
      wr(16'h0a22, 8'h01);
      wr(PIN_CODE_BASE, 8'h4c);
      @(posedge ref_clk);
      drive[0] <= 1'b1;
      tick(2);
      `CHK("pin or register", 8'h21, ctrl[7])
      rd(16'h0a22, d);
      `CHK("register kept", 8'h01, d)
      @(posedge ref_clk);
      drive[0] <= 1'b0;
      wr(16'h0a22, 8'h00);
      wr(PIN_CODE_BASE, 8'h00);
      $display("test pin and register done");
      wr(16'h0a05, 8'hf1);
      tick(1);
      `CHK("clear register applied", 8'hf1, ctrl[4])
      tick(1);
      `CHK("clear bits self-clear", 8'h70, ctrl[4])
      wr(16'h0a05, 8'h00);
      $display("test strobe register done");
      for (int i = 0; i < 40; i++) begin
         r = {$random(seed), $random(seed), $random(seed)};
         c = (i == 0) ? OUT_SYNC_B : (i == 1) ? OUT_IRQ_ANY : (i == 2) ? OUT_RSVD_FIRST :
             (i == 3) ? OUT_FIRST : (i == 4) ? OUT_HIGH : 8'h84 + 8'($unsigned($random(seed)) % 124);
         p = (i < 5) ? 0 : i % 4;
         exp = (c >= OUT_RSVD_FIRST || c == OUT_FIRST) ? 1'b0 : (c == OUT_HIGH) ? 1'b1 :
               (c == OUT_IRQ_ANY) ? |r[19:17] : r[c - OUT_FIRST];
         @(posedge ref_clk);
         status.bits <= r[92:0];
         wr(PIN_CODE_BASE + 16'(p), c);
         tick(1);
         `CHK("pin oe", c < OUT_RSVD_FIRST, pin_oe[p])
         `CHK("pin level", exp, pin_out[p])
         wr(PIN_CODE_BASE + 16'(p), 8'h00);
      end
      rd(STATUS_ADDR, d);
      `CHK("sync status", {3'b000, r[92], 4'h0}, d)
      wr(PIN_CODE_BASE + 16'h0002, OUT_DIV32);
      tick(2);
      exp = pin_out[2];
      tick(16);
      `CHK("divided clock half period", ~exp, pin_out[2])
      wr(PIN_CODE_BASE + 16'h0002, 8'h00);
      $display("test output codes done");
      wr(PIN_CODE_BASE, OUT_WATCHDOG);
      @(posedge ref_clk);
      status.wd_expire <= 1'b1;
      @(posedge ref_clk);
      status.wd_expire <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         tick(1);
         `CHK("watchdog strobe", 1'b1, pin_out[0])
      end
      tick(1);
      `CHK("watchdog strobe end", 1'b0, pin_out[0])
      $display("test watchdog done");
      summarize();
   end
endmodule
`undef CHK
`default_nettype wire
